//--- hw/ces_exec_state.sv
// Overview of operation
// - Load/store byte order is memory byte order XOR the swap signal.
// - Swap signal is active only with the status swap bit set in user mode.
// - Linked load sets the reservation flag; conditional store tests then clears it.
// - Reservation clears when atomicity is lost, including an exception return that raises no exception and is not also a linked load.
// - Unlabelled effects of an instruction land within its own instruction time.
// - Deferred effects land together with the next instruction's own effects.
// - Updates within one instruction apply in their written order.
// - Without a new PC value, PC steps by 2 for short, 4 otherwise.
// - Taken branch target loads during the delay slot instruction's time.
// - Physical address width is a parameter; space spans two to that power.
// - Segment address width is a parameter; segment spans two to that power.
// - Wide mode gives 32 registers of 64 bits, any holding doubles.
// - Compatibility mode keeps doubles in even-odd register pairs.
// - Status width bit 0 selects 32-bit registers, 1 selects 64-bit.
// - Delay slot indicator set only for instructions truly in a delay slot.
// - Exception records type and argument and ends the instruction for good.
// - Signed add word: opcode 000000, sources, dest, zero 10:6, function 100000.
// - Memory byte order is fixed at reset: 0 little, 1 big.
`timescale 1ns/1ns
module ces_exec_state
    import ces_pkg::*;
#(
    parameter int PHYS_ADDR_WIDTH = 36,
    parameter int SEGMENT_ADDR_WIDTH = 40,
    parameter logic [63:0] RESET_PC = 64'h0000_0000_0000_0000,
    parameter logic [63:0] EXC_VECTOR = 64'h0000_0000_0000_0100
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mem_byte_order_big,
    input wire logic insn_valid,
    input wire logic [31:0] insn_word,
    input wire logic insn_short,
    input wire logic insn_ll,
    input wire logic insn_sc,
    input wire logic insn_eret,
    input wire logic [63:0] ll_paddr,
    input wire logic branch_taken,
    input wire logic [63:0] branch_target,
    input wire logic store_valid,
    input wire logic [63:0] store_paddr,
    input wire logic exc_req,
    input wire logic [4:0] exc_code,
    input wire logic [63:0] exc_arg,
    input wire logic fp_wr_en,
    input wire logic fp_wr_dbl,
    input wire logic [4:0] fp_wr_idx,
    input wire logic [63:0] fp_wr_data,
    input wire logic [4:0] fp_rd_idx,
    input wire logic fp_rd_dbl,
    output logic [63:0] fp_rd_data,
    output logic cpu_byte_order_big,
    output logic byte_order_swap_active,
    output logic link_reservation_flag,
    output logic sc_done,
    output logic sc_success,
    output logic in_delay_slot_flag,
    output logic [63:0] pc,
    output logic raise_exception,
    output logic [4:0] exc_code_out,
    output logic [63:0] exc_arg_out,
    output logic fpu_narrow_reg_mode,
    output logic add_decoded,
    output logic reserved_field_nz,
    output logic [4:0] src_reg_a,
    output logic [4:0] src_reg_b,
    output logic [4:0] dst_reg
);

    // Address widths are configuration; physical width also masks reservation compares; spaces span two to these powers
    if (PHYS_ADDR_WIDTH < 1 || PHYS_ADDR_WIDTH > 64) begin : g_bad_phys
        $error("ces_exec_state: physical address width out of range");
    end
    if (SEGMENT_ADDR_WIDTH < 1 || SEGMENT_ADDR_WIDTH > 64) begin : g_bad_seg
        $error("ces_exec_state: segment address width out of range");
    end

    localparam logic [63:0] PHYS_MASK = 64'hFFFF_FFFF_FFFF_FFFF >> (64 - PHYS_ADDR_WIDTH);
    localparam logic [7:0] PHYS_W8 = 8'(PHYS_ADDR_WIDTH);
    localparam logic [7:0] SEG_W8 = 8'(SEGMENT_ADDR_WIDTH);

    typedef struct packed {
        logic strap_s1;
        logic strap_s2;
        logic [1:0] strap_cnt;
        logic mem_big;
        logic [CES_CTRL_W-1:0] ctrl;
        logic swap;
        logic cpu_big;
        logic narrow;
        logic ll;
        logic [63:0] res_addr;
        logic sc_done;
        logic sc_ok;
        ces_seq_t seq;
        logic [63:0] slot_target;
        logic in_slot;
        logic [63:0] pc;
        logic exc_sig;
        logic [CES_EXC_W-1:0] exc_code;
        logic [63:0] exc_arg;
        logic add_dec;
        logic rsv_nz;
        logic [4:0] src_a;
        logic [4:0] src_b;
        logic [4:0] dst;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ces_main_st_t;

    localparam ces_main_st_t ST_RST = '{
        default: '0,
        ctrl: CES_CTRL_RST,
        narrow: 1'b1,
        seq: CES_SEQ_LINEAR,
        pc: RESET_PC
    };

    ces_main_st_t st_q;
    ces_main_st_t st_d;

    logic dec_add;
    logic dec_rsv;
    logic [4:0] dec_a;
    logic [4:0] dec_b;
    logic [4:0] dec_dst;

    ces_insn_dec u_dec (
        .insn(insn_word),
        .is_add(dec_add),
        .rsv_nz(dec_rsv),
        .src_a(dec_a),
        .src_b(dec_b),
        .dst(dec_dst)
    );

    ces_fpr_mem #(
        .DEPTH(32),
        .WIDTH(64)
    ) u_fpr (
        .clk(pclk),
        .rst_n(presetn),
        .narrow(st_q.narrow),
        .wr_en(fp_wr_en),
        .wr_dbl(fp_wr_dbl),
        .wr_idx(fp_wr_idx),
        .wr_data(fp_wr_data),
        .rd_idx(fp_rd_idx),
        .rd_dbl(fp_rd_dbl),
        .rd_data(fp_rd_data)
    );

    function automatic logic ces_addr_hit(input logic [7:0] a);
        ces_addr_hit = (a == CES_OFF_CTRL) || (a == CES_OFF_STATE) || (a == CES_OFF_PC_LO)
            || (a == CES_OFF_PC_HI) || (a == CES_OFF_EXC) || (a == CES_OFF_EXC_ARG_LO)
            || (a == CES_OFF_EXC_ARG_HI) || (a == CES_OFF_CFG);
    endfunction : ces_addr_hit

    always_comb begin
        logic [31:0] rd_val;
        logic [31:0] state_w;
        logic xfer;
        st_d = st_q;
        rd_val = '0;
        state_w = '0;
        xfer = insn_valid && !exc_req;

        // Memory byte order strap: synchronised, then frozen after reset
        st_d.strap_s1 = mem_byte_order_big;
        st_d.strap_s2 = st_q.strap_s1;
        if (st_q.strap_cnt != CES_STRAP_WAIT + 2'h1) begin
            st_d.strap_cnt = st_q.strap_cnt + 2'h1;
        end
        if (st_q.strap_cnt == CES_STRAP_WAIT) begin
            st_d.mem_big = st_q.strap_s2;
        end

        // Register bus: zero wait states, answer registered in setup cycle
        st_d.pready = 1'b0;
        st_d.pslverr = 1'b0;
        st_d.prdata = '0;
        state_w[CES_ST_CPU_BIG] = st_q.cpu_big;
        state_w[CES_ST_SWAP] = st_q.swap;
        state_w[CES_ST_LINK] = st_q.ll;
        state_w[CES_ST_SLOT] = st_q.in_slot;
        state_w[CES_ST_FPU_NARROW] = st_q.narrow;
        state_w[CES_ST_MEM_BIG] = st_q.mem_big;
        state_w[CES_ST_RSV_NZ] = st_q.rsv_nz;
        case (paddr)
            CES_OFF_CTRL: rd_val = {{(32 - CES_CTRL_W){1'b0}}, st_q.ctrl};
            CES_OFF_STATE: rd_val = state_w;
            CES_OFF_PC_LO: rd_val = st_q.pc[31:0];
            CES_OFF_PC_HI: rd_val = st_q.pc[63:32];
            CES_OFF_EXC: rd_val = {{(32 - CES_EXC_W){1'b0}}, st_q.exc_code};
            CES_OFF_EXC_ARG_LO: rd_val = st_q.exc_arg[31:0];
            CES_OFF_EXC_ARG_HI: rd_val = st_q.exc_arg[63:32];
            CES_OFF_CFG: rd_val = 32'(SEG_W8) << CES_CFG_SEG_LSB | 32'(PHYS_W8) << CES_CFG_PHYS_LSB;
            default: rd_val = '0;
        endcase
        if (psel && !penable) begin
            st_d.pready = 1'b1;
            st_d.pslverr = !ces_addr_hit(paddr);
            if (!pwrite && ces_addr_hit(paddr)) begin
                st_d.prdata = rd_val;
            end
        end
        if (psel && penable && st_q.pready && pwrite && paddr == CES_OFF_CTRL && pstrb[0]) begin
            st_d.ctrl = pwdata[CES_CTRL_W-1:0];
        end

        st_d.swap = st_d.ctrl[CES_CTRL_SWAP_BIT] && st_d.ctrl[CES_CTRL_USER_BIT];
        st_d.cpu_big = st_d.mem_big ^ st_d.swap;
        st_d.narrow = !st_d.ctrl[CES_CTRL_FPU_WIDTH_BIT];

        // Effects of one instruction land in its single valid cycle; a taken branch target lands with the delay slot instruction
        st_d.sc_done = 1'b0;
        st_d.exc_sig = 1'b0;
        if (store_valid && st_q.ll
                && (store_paddr & PHYS_MASK) == (st_q.res_addr & PHYS_MASK)) begin
            st_d.ll = 1'b0;
        end
        if (insn_valid && exc_req) begin
            // Exception ends the sequence; no other effect of this instruction lands
            st_d.exc_sig = 1'b1;
            st_d.exc_code = exc_code;
            st_d.exc_arg = exc_arg;
            st_d.pc = EXC_VECTOR;
            st_d.seq = CES_SEQ_LINEAR;
            st_d.in_slot = 1'b0;
        end else if (xfer) begin
            st_d.add_dec = dec_add;
            st_d.rsv_nz = dec_rsv;
            st_d.src_a = dec_a;
            st_d.src_b = dec_b;
            st_d.dst = dec_dst;
            // Conditional store tests the flag, then clears it, in that order
            if (insn_sc) begin
                st_d.sc_done = 1'b1;
                st_d.sc_ok = st_q.ll;
                st_d.ll = 1'b0;
            end
            if (insn_eret) begin
                st_d.ll = 1'b0;
            end
            if (insn_ll) begin
                st_d.ll = 1'b1;
                st_d.res_addr = ll_paddr & PHYS_MASK;
            end
            unique case (st_q.seq)
                CES_SEQ_LINEAR: begin
                    st_d.in_slot = 1'b0;
                    st_d.pc = st_q.pc + (insn_short ? CES_PC_STEP_SHORT : CES_PC_STEP_LONG);
                    if (branch_taken) begin
                        st_d.slot_target = branch_target;
                        st_d.seq = CES_SEQ_DELAY;
                    end
                end
                CES_SEQ_DELAY: begin
                    st_d.in_slot = 1'b1;
                    st_d.pc = st_q.slot_target;
                    st_d.seq = CES_SEQ_LINEAR;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign cpu_byte_order_big = st_q.cpu_big;
    assign byte_order_swap_active = st_q.swap;
    assign link_reservation_flag = st_q.ll;
    assign sc_done = st_q.sc_done;
    assign sc_success = st_q.sc_ok;
    assign in_delay_slot_flag = st_q.in_slot;
    assign pc = st_q.pc;
    assign raise_exception = st_q.exc_sig;
    assign exc_code_out = st_q.exc_code;
    assign exc_arg_out = st_q.exc_arg;
    assign fpu_narrow_reg_mode = st_q.narrow;
    assign add_decoded = st_q.add_dec;
    assign reserved_field_nz = st_q.rsv_nz;
    assign src_reg_a = st_q.src_a;
    assign src_reg_b = st_q.src_b;
    assign dst_reg = st_q.dst;

    default clocking ces_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence ces_branch_s;
        insn_valid && !exc_req && branch_taken && st_q.seq == CES_SEQ_LINEAR;
    endsequence
    sequence ces_slot_s;
        insn_valid && !exc_req && st_q.seq == CES_SEQ_DELAY;
    endsequence

    endian_xor_a: assert property (
        cpu_byte_order_big == (st_q.mem_big ^ byte_order_swap_active))
        else $error("load/store byte order not memory order xor swap");

    swap_gate_a: assert property (
        byte_order_swap_active == (st_q.ctrl[CES_CTRL_SWAP_BIT] && st_q.ctrl[CES_CTRL_USER_BIT]))
        else $error("swap active without swap bit in user mode");

    ll_set_a: assert property (
        insn_valid && !exc_req && insn_ll |=> link_reservation_flag)
        else $error("linked load did not set reservation");

    sc_test_a: assert property (
        insn_valid && !exc_req && insn_sc && !insn_ll
        |=> sc_done && !link_reservation_flag && sc_success == $past(link_reservation_flag))
        else $error("conditional store did not test and clear reservation");

    eret_clear_a: assert property (
        insn_valid && !exc_req && insn_eret && !insn_ll |=> !link_reservation_flag)
        else $error("exception return left reservation set");

    pc_step_a: assert property (
        insn_valid && !exc_req && st_q.seq == CES_SEQ_LINEAR
        |=> pc == $past(pc) + ($past(insn_short) ? CES_PC_STEP_SHORT : CES_PC_STEP_LONG))
        else $error("sequential pc step wrong");

    branch_arm_a: assert property (
        ces_branch_s |=> st_q.seq == CES_SEQ_DELAY && st_q.slot_target == $past(branch_target))
        else $error("taken branch did not arm the delay slot");
    branch_slot_a: assert property (
        ces_slot_s |=> pc == $past(st_q.slot_target) && in_delay_slot_flag)
        else $error("branch target not taken in delay slot");

    slot_flag_a: assert property (
        insn_valid && !exc_req |=> in_delay_slot_flag == ($past(st_q.seq) == CES_SEQ_DELAY))
        else $error("delay slot indicator wrong");

    exc_record_a: assert property (
        insn_valid && exc_req
        |=> raise_exception && exc_code_out == $past(exc_code) && pc == EXC_VECTOR
            && !in_delay_slot_flag && st_q.seq == CES_SEQ_LINEAR)
        else $error("exception not recorded or sequence resumed");

    fpu_mode_a: assert property (
        fpu_narrow_reg_mode == !st_q.ctrl[CES_CTRL_FPU_WIDTH_BIT])
        else $error("fpu register width mode wrong");

    add_decode_a: assert property (
        insn_valid && !exc_req && insn_word[31:26] == 6'h00 && insn_word[5:0] == 6'h20
        && insn_word[10:6] == 5'h00 |=> add_decoded && dst_reg == $past(insn_word[15:11]))
        else $error("signed add word not decoded");

endmodule : ces_exec_state

//--- inc/ces_pkg.sv
package ces_pkg;

    // Register byte offsets
    localparam logic [7:0] CES_OFF_CTRL = 8'h00;
    localparam logic [7:0] CES_OFF_STATE = 8'h04;
    localparam logic [7:0] CES_OFF_PC_LO = 8'h08;
    localparam logic [7:0] CES_OFF_PC_HI = 8'h0C;
    localparam logic [7:0] CES_OFF_EXC = 8'h10;
    localparam logic [7:0] CES_OFF_EXC_ARG_LO = 8'h14;
    localparam logic [7:0] CES_OFF_EXC_ARG_HI = 8'h18;
    localparam logic [7:0] CES_OFF_CFG = 8'h1C;

    // Control register fields and reset value
    localparam int CES_CTRL_W = 3;
    localparam int CES_CTRL_SWAP_BIT = 0;
    localparam int CES_CTRL_FPU_WIDTH_BIT = 1;
    localparam int CES_CTRL_USER_BIT = 2;
    localparam logic [2:0] CES_CTRL_RST = 3'h0;

    // State register field positions
    localparam int CES_ST_CPU_BIG = 0;
    localparam int CES_ST_SWAP = 1;
    localparam int CES_ST_LINK = 2;
    localparam int CES_ST_SLOT = 3;
    localparam int CES_ST_FPU_NARROW = 4;
    localparam int CES_ST_MEM_BIG = 5;
    localparam int CES_ST_RSV_NZ = 6;

    // Configuration register field positions
    localparam int CES_CFG_PHYS_LSB = 0;
    localparam int CES_CFG_SEG_LSB = 8;

    // Instruction word encodings
    localparam logic [5:0] CES_OP_SPECIAL = 6'h00;
    localparam logic [5:0] CES_FN_ADD = 6'h20;
    localparam logic [4:0] CES_SHAMT_ZERO = 5'h00;

    // Program counter steps and strap capture delay
    localparam logic [63:0] CES_PC_STEP_SHORT = 64'h0000_0000_0000_0002;
    localparam logic [63:0] CES_PC_STEP_LONG = 64'h0000_0000_0000_0004;
    localparam logic [1:0] CES_STRAP_WAIT = 2'h2;

    localparam int CES_EXC_W = 5;

    typedef enum logic [1:0] {
        CES_SEQ_LINEAR = 2'b01,
        CES_SEQ_DELAY = 2'b10
    } ces_seq_t;

endpackage : ces_pkg

//--- hw/ces_insn_dec.sv
`timescale 1ns/1ns
module ces_insn_dec
    import ces_pkg::*;
(
    input wire logic [31:0] insn,
    output logic is_add,
    output logic rsv_nz,
    output logic [4:0] src_a,
    output logic [4:0] src_b,
    output logic [4:0] dst
);

    function automatic logic [4:0] ces_field5(input logic [31:0] w, input int lsb);
        ces_field5 = w[lsb +: 5];
    endfunction : ces_field5

    // Register-form layout: opcode 31:26, sources 25:21 and 20:16, dest 15:11
    always_comb begin
        src_a = ces_field5(insn, 21);
        src_b = ces_field5(insn, 16);
        dst = ces_field5(insn, 11);
        rsv_nz = (insn[31:26] == CES_OP_SPECIAL) && (ces_field5(insn, 6) != CES_SHAMT_ZERO);
        is_add = (insn[31:26] == CES_OP_SPECIAL) && (insn[5:0] == CES_FN_ADD)
            && (ces_field5(insn, 6) == CES_SHAMT_ZERO);
    end

endmodule : ces_insn_dec

//--- hw/ces_fpr_mem.sv
`timescale 1ns/1ns
module ces_fpr_mem #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 64
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic narrow,
    input wire logic wr_en,
    input wire logic wr_dbl,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    input wire logic rd_dbl,
    output logic [WIDTH-1:0] rd_data
);

    localparam int IW = $clog2(DEPTH);
    localparam int HALF = WIDTH / 2;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 2 || WIDTH % 2 != 0) begin : g_bad
        $error("ces_fpr_mem: depth must be a power of two, width even");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] ent;
        logic [WIDTH-1:0] rd;
    } ces_fpr_st_t;

    ces_fpr_st_t st_q;
    ces_fpr_st_t st_d;

    always_comb begin
        logic [IW-1:0] w_ev;
        logic [IW-1:0] w_od;
        logic [IW-1:0] r_ev;
        logic [IW-1:0] r_od;
        w_ev = {wr_idx[IW-1:1], 1'b0};
        w_od = {wr_idx[IW-1:1], 1'b1};
        r_ev = {rd_idx[IW-1:1], 1'b0};
        r_od = {rd_idx[IW-1:1], 1'b1};
        st_d = st_q;
        if (wr_en) begin
            if (!narrow) begin
                st_d.ent[wr_idx] = wr_data;
            end else if (wr_dbl) begin
                st_d.ent[w_ev][HALF-1:0] = wr_data[HALF-1:0];
                st_d.ent[w_od][HALF-1:0] = wr_data[WIDTH-1:HALF];
            end else begin
                st_d.ent[wr_idx][HALF-1:0] = wr_data[HALF-1:0];
            end
        end
        if (!narrow) begin
            st_d.rd = st_q.ent[rd_idx];
        end else if (rd_dbl) begin
            st_d.rd = {st_q.ent[r_od][HALF-1:0], st_q.ent[r_ev][HALF-1:0]};
        end else begin
            st_d.rd = {{HALF{1'b0}}, st_q.ent[rd_idx][HALF-1:0]};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data = st_q.rd;

endmodule : ces_fpr_mem

//--- tb/ces_mem_model.sv
`timescale 1ns/1ns
module ces_mem_model #(
    parameter logic BIG = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic st_req,
    input wire logic [63:0] st_addr,
    output logic mem_byte_order_big,
    output logic store_valid,
    output logic [63:0] store_paddr
);
    // Strap held stable for the whole run
    assign mem_byte_order_big = BIG;
    // Store address changes every idle cycle so nothing stale is seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            store_valid <= 1'b0;
            store_paddr <= '0;
        end else begin
            store_valid <= st_req;
            store_paddr <= st_req ? st_addr : ~store_paddr;
        end
    end
endmodule : ces_mem_model

//--- tb/tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module tb_top
    import ces_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, errv;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, insn_word, rdv;
    logic insn_valid, st_req, store_valid, mem_byte_order_big;
    logic [5:0] ictl;
    logic [63:0] store_paddr, branch_target, fp_wr_data, fp_rd_data, pc, exc_arg_out, p0;
    logic fp_wr_en, fp_wr_dbl, fp_rd_dbl, cpu_byte_order_big, byte_order_swap_active;
    logic link_reservation_flag, sc_done, sc_success, in_delay_slot_flag, raise_exception;
    logic fpu_narrow_reg_mode, add_decoded, reserved_field_nz;
    logic [4:0] fp_wr_idx, fp_rd_idx, exc_code_out, src_reg_a, src_reg_b, dst_reg;
    int n_errors, total_checks, cycles;
    localparam logic [63:0] LL_ADDR = 64'h0000_0000_0000_1000;
    localparam logic [63:0] TGT = 64'h0000_0000_0000_4000;
    localparam logic [63:0] EXC_DATA = 64'h0000_0000_dead_0004;
    localparam logic [4:0] EXC_TYPE = 5'h0c;

    ces_mem_model far_u (.pclk(pclk), .presetn(presetn), .st_req(st_req), .st_addr(LL_ADDR),
        .mem_byte_order_big(mem_byte_order_big), .store_valid(store_valid),
        .store_paddr(store_paddr));
    ces_exec_state dut_u (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_byte_order_big(mem_byte_order_big), .insn_valid(insn_valid),
        .insn_word(insn_word), .insn_short(ictl[0]), .insn_ll(ictl[1]), .insn_sc(ictl[2]),
        .insn_eret(ictl[3]), .ll_paddr(LL_ADDR), .branch_taken(ictl[4]),
        .branch_target(branch_target), .store_valid(store_valid), .store_paddr(store_paddr),
        .exc_req(ictl[5]), .exc_code(EXC_TYPE), .exc_arg(EXC_DATA), .fp_wr_en(fp_wr_en),
        .fp_wr_dbl(fp_wr_dbl), .fp_wr_idx(fp_wr_idx), .fp_wr_data(fp_wr_data),
        .fp_rd_idx(fp_rd_idx), .fp_rd_dbl(fp_rd_dbl), .fp_rd_data(fp_rd_data),
        .cpu_byte_order_big(cpu_byte_order_big), .byte_order_swap_active(byte_order_swap_active),
        .link_reservation_flag(link_reservation_flag), .sc_done(sc_done),
        .sc_success(sc_success), .in_delay_slot_flag(in_delay_slot_flag), .pc(pc),
        .raise_exception(raise_exception), .exc_code_out(exc_code_out),
        .exc_arg_out(exc_arg_out), .fpu_narrow_reg_mode(fpu_narrow_reg_mode),
        .add_decoded(add_decoded), .reserved_field_nz(reserved_field_nz),
        .src_reg_a(src_reg_a), .src_reg_b(src_reg_b), .dst_reg(dst_reg));

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr_ctrl(input logic [31:0] d);
        apb(1'b1, CES_OFF_CTRL, d);
        @(posedge pclk);
        #1;
    endtask : wr_ctrl

    // Control bits: 0 short, 1 linked load, 2 cond store, 3 eret, 4 branch, 5 exception
    task automatic run_insn(input logic [5:0] f, input logic [31:0] w);
        @(posedge pclk);
        insn_valid <= 1'b1;
        ictl <= f;
        insn_word <= w;
        @(posedge pclk);
        insn_valid <= 1'b0;
        ictl <= '0;
        #1;
    endtask : run_insn

    task automatic fp_rt(input logic [4:0] i, input logic dbl, input logic [63:0] d);
        @(posedge pclk);
        fp_wr_en <= 1'b1;
        fp_wr_dbl <= dbl;
        fp_wr_idx <= i;
        fp_wr_data <= d;
        @(posedge pclk);
        fp_wr_en <= 1'b0;
        fp_rd_idx <= i;
        fp_rd_dbl <= dbl;
        @(posedge pclk);
        #1;
        `CHK("fp_rd_data", d, fp_rd_data)
    endtask : fp_rt

    task automatic endian_chk();
        wr_ctrl(32'h0000_0001);
        `CHK("swap_kernel", 1'b0, byte_order_swap_active)
        `CHK("order_kernel", 1'b1, cpu_byte_order_big)
        wr_ctrl(32'h0000_0005);
        `CHK("swap_user", 1'b1, byte_order_swap_active)
        `CHK("order_user", 1'b0, cpu_byte_order_big)
        wr_ctrl(32'h0000_0002);
        `CHK("fpu_narrow", 1'b0, fpu_narrow_reg_mode)
        apb(1'b0, CES_OFF_STATE, 32'h0000_0000);
        `CHK("state", 32'h0000_0021, rdv)
        apb(1'b0, CES_OFF_CFG, 32'h0000_0000);
        `CHK("cfg", 32'h0000_2824, rdv)
        apb(1'b0, 8'h40, 32'h0000_0000);
        `CHK("unmapped_err", 1'b1, errv)
    endtask : endian_chk

    task automatic pc_chk();
        p0 = pc;
        run_insn(6'h00, 32'h0000_0000);
        `CHK("pc_long", p0 + 64'h0000_0000_0000_0004, pc)
        run_insn(6'h01, 32'h0000_0000);
        `CHK("pc_short", p0 + 64'h0000_0000_0000_0006, pc)
        p0 = pc;
        run_insn(6'h10, 32'h0000_0000);
        `CHK("pc_branch", p0 + 64'h0000_0000_0000_0004, pc)
        `CHK("slot_branch", 1'b0, in_delay_slot_flag)
        run_insn(6'h00, 32'h0000_0000);
        `CHK("pc_slot", TGT, pc)
        `CHK("slot_set", 1'b1, in_delay_slot_flag)
        run_insn(6'h00, 32'h0000_0000);
        `CHK("pc_after", TGT + 64'h0000_0000_0000_0004, pc)
        `CHK("slot_clear", 1'b0, in_delay_slot_flag)
    endtask : pc_chk

    task automatic link_chk();
        run_insn(6'h02, 32'h0000_0000);
        `CHK("link_set", 1'b1, link_reservation_flag)
        run_insn(6'h04, 32'h0000_0000);
        `CHK("sc_ok", 2'b11, {sc_done, sc_success})
        `CHK("link_sc", 1'b0, link_reservation_flag)
        run_insn(6'h04, 32'h0000_0000);
        `CHK("sc_fail", 2'b10, {sc_done, sc_success})
        run_insn(6'h02, 32'h0000_0000);
        @(posedge pclk);
        st_req <= 1'b1;
        @(posedge pclk);
        st_req <= 1'b0;
        @(posedge pclk);
        #1;
        `CHK("link_store", 1'b0, link_reservation_flag)
        run_insn(6'h02, 32'h0000_0000);
        run_insn(6'h08, 32'h0000_0000);
        `CHK("link_eret", 1'b0, link_reservation_flag)
        run_insn(6'h22, 32'h0000_0000);
        `CHK("exc_link", 1'b0, link_reservation_flag)
        `CHK("exc_pulse", 1'b1, raise_exception)
        `CHK("exc_code", EXC_TYPE, exc_code_out)
        `CHK("exc_arg", EXC_DATA, exc_arg_out)
        `CHK("exc_pc", 64'h0000_0000_0000_0100, pc)
    endtask : link_chk

    task automatic dec_chk();
        run_insn(6'h00, {6'h00, 5'h03, 5'h07, 5'h09, 5'h00, 6'h20});
        `CHK("add", 4'h8, {add_decoded, 2'b00, reserved_field_nz})
        `CHK("regs", {5'h03, 5'h07, 5'h09}, {src_reg_a, src_reg_b, dst_reg})
        // Reserved field deliberately nonzero here
        run_insn(6'h00, {6'h00, 5'h03, 5'h07, 5'h09, 5'h01, 6'h20});
        `CHK("rsv_nz", 1'b1, reserved_field_nz)
    endtask : dec_chk

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles >= 5000) begin
            n_errors++;
            summarize();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, insn_valid, st_req} = '0;
        {fp_wr_en, fp_wr_dbl, fp_rd_dbl, ictl, paddr, pwdata, insn_word} = '0;
        {fp_wr_idx, fp_rd_idx, fp_wr_data} = '0;
        branch_target = TGT;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        #1;
        `CHK("pc_reset", 64'h0000_0000_0000_0000, pc)
        `CHK("link_reset", 1'b0, link_reservation_flag)
        `CHK("narrow_reset", 1'b1, fpu_narrow_reg_mode)
        `CHK("order_reset", 1'b1, cpu_byte_order_big)
        endian_chk();
        fp_rt(5'h05, 1'b1, 64'h1234_5678_9abc_def1);
        wr_ctrl(32'h0000_0000);
        fp_rt(5'h06, 1'b1, 64'h0fed_cba9_8765_4321);
        fp_rt(5'h09, 1'b0, 64'h0000_0000_1357_9bdf);
        pc_chk();
        link_chk();
        dec_chk();
        summarize();
    end
endmodule : tb_top
